//--- twr_pkg.sv
/*
 Constants for the two-wire register slave: slave addresses, the special
 low-byte port address and the protocol state type.
 Assumes one clock domain (mclk) inside the slave.
*/
package twr_pkg;
    // 7-bit slave addresses chosen by the address-select pin
    localparam logic [6:0] SLAVE_ADDR_HI  = 7'h5c;
    localparam logic [6:0] SLAVE_ADDR_LO  = 7'h48;
    // Register address of low_byte_access_port
    localparam logic [7:0] LOW_BYTE_PORT  = 8'h7f;
    localparam logic [15:0] REG_RESET     = 16'h0000;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam logic [1:0] IDX_SLAVE      = 2'h0;
    localparam logic [1:0] IDX_REGADDR    = 2'h1;
    localparam logic [1:0] IDX_DATA       = 2'h2;

    typedef enum logic [2:0] {
        st_idle,
        st_rx,
        st_ack,
        st_tx,
        st_rack
    } proto_state_t;
endpackage : twr_pkg

//--- two_wire_register_slave.sv
/*
 Two-wire serial slave giving a bus master access to 16-bit registers,
 with auto-increment and a byte-wise low-byte port.
 Assumes the serial clock and data pins are slow against mclk and that an
 external pull-up and wire resolution turn the data enable into a level.
*/
`timescale 1ns/100ps

module two_wire_register_slave
    import twr_pkg::*;
#(
    parameter int REG_COUNT = 127
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        serial_clock_line,
    input  wire logic        serial_data_line_pin,
    input  wire logic        addr_select,
    input  wire logic [7:0]  cfg_index,
    output logic             serial_data_line_drive,
    output logic             serial_data_line_en,
    output logic             reg_wr_strobe_q,
    output logic [7:0]       reg_wr_addr_q,
    output logic [15:0]      reg_wr_data_q,
    output logic [15:0]      cfg_value_q,
    output logic             busy_q
);
    localparam int IDX_W = $clog2(REG_COUNT);
    localparam logic [7:0] REG_LIMIT = 8'(REG_COUNT);

    // Index width and limit compare only serve 2..127 registers
    if (REG_COUNT < 2 || REG_COUNT > 127) begin : g_bad_count
        $error("REG_COUNT must lie in 2..127");
    end

    logic [15:0]  regs [REG_COUNT];
    logic [2:0]   scl_q;
    logic [2:0]   sda_q;
    logic [1:0]   sel_q;
    proto_state_t state_q;
    logic [3:0]   bit_cnt_q;
    logic [7:0]   shreg_q;
    logic [7:0]   tx_q;
    logic [1:0]   byte_idx_q;
    logic         rw_q;
    logic         mack_q;
    logic         oe_q;
    logic         drive_q;
    logic [7:0]   reg_addr_q;
    logic [7:0]   pend_addr_q;
    logic [7:0]   hi_q;
    logic [7:0]   lo_q;
    logic         wphase_q;
    logic         rphase_q;
    logic         scl_s;
    logic         scl_p;
    logic         sda_s;
    logic         sda_p;
    logic         scl_rise;
    logic         scl_fall;
    logic         start_det;
    logic         stop_det;
    logic         rx_done;
    logic         addr_hit;
    logic         take_data;
    logic         load_tx;
    logic [6:0]   my_addr;
    logic [15:0]  cur_reg;
    logic [7:0]   rd_byte;

    // Two-stage sync, third stage for edges
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            sel_q <= 2'h0;
        end else begin
            scl_q <= {scl_q[1:0], serial_clock_line};
            sda_q <= {sda_q[1:0], serial_data_line_pin};
            sel_q <= {sel_q[0], addr_select};
        end
    end

    assign scl_s    = scl_q[1];
    assign scl_p    = scl_q[2];
    assign sda_s    = sda_q[1];
    assign sda_p    = sda_q[2];
    assign scl_rise = scl_s & ~scl_p;
    assign scl_fall = ~scl_s & scl_p;
    assign start_det = scl_s & scl_p & sda_p & ~sda_s;
    assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;

    // Select high address, select low address
    assign my_addr   = sel_q[1] ? SLAVE_ADDR_HI : SLAVE_ADDR_LO;
    // Seven address bits above the direction bit
    assign addr_hit  = shreg_q[7:1] == my_addr;
    // Byte complete at the falling edge after eight bits
    assign rx_done   = state_q == st_rx && scl_fall && bit_cnt_q == BITS_PER_BYTE;
    assign take_data = rx_done && byte_idx_q == IDX_DATA;
    assign load_tx   = scl_fall && ((state_q == st_ack && rw_q) ||
                                    (state_q == st_rack && mack_q));

    assign cur_reg = (reg_addr_q < REG_LIMIT) ? regs[reg_addr_q[IDX_W-1:0]] : REG_RESET;

    // Low port returns the latched lower byte
    always_comb begin
        if (rphase_q || reg_addr_q == LOW_BYTE_PORT) begin
            rd_byte = lo_q;
        end else begin
            rd_byte = cur_reg[15:8];
        end
    end

    // Protocol engine
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= st_idle;
            bit_cnt_q  <= 4'h0;
            shreg_q    <= 8'h00;
            tx_q       <= 8'h00;
            byte_idx_q <= IDX_SLAVE;
            rw_q       <= 1'b0;
            mack_q     <= 1'b0;
            oe_q       <= 1'b0;
        end else if (start_det) begin
            // Start or repeated start restarts framing
            state_q    <= st_rx;
            bit_cnt_q  <= 4'h0;
            byte_idx_q <= IDX_SLAVE;
            oe_q       <= 1'b0;
        end else if (stop_det) begin
            // Stop ends and releases; write ends here too
            state_q <= st_idle;
            oe_q    <= 1'b0;
        end else begin
            case (state_q)
                st_rx: begin
                    if (scl_rise) begin
                        shreg_q   <= {shreg_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (rx_done) begin
                        if (byte_idx_q != IDX_SLAVE || addr_hit) begin
                            oe_q    <= 1'b1;
                            state_q <= st_ack;
                        end else begin
                            state_q <= st_idle;
                        end
                        if (byte_idx_q == IDX_SLAVE) begin
                            rw_q <= shreg_q[0];
                        end
                        if (byte_idx_q != IDX_DATA) begin
                            byte_idx_q <= byte_idx_q + 2'h1;
                        end
                    end
                end
                st_ack: begin
                    if (load_tx) begin
                        // Read data follows the address ack
                        tx_q      <= rd_byte;
                        oe_q      <= ~rd_byte[7];
                        bit_cnt_q <= 4'h0;
                        state_q   <= st_tx;
                    end else if (scl_fall) begin
                        oe_q      <= 1'b0;
                        bit_cnt_q <= 4'h0;
                        state_q   <= st_rx;
                    end
                end
                st_tx: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_q == BITS_PER_BYTE) begin
                            oe_q    <= 1'b0;
                            mack_q  <= 1'b0;
                            state_q <= st_rack;
                        end else begin
                            // Change data only after clock falls
                            oe_q <= ~tx_q[3'h7 - bit_cnt_q[2:0]];
                        end
                    end
                end
                st_rack: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state_q <= st_idle;
                        end else begin
                            mack_q <= 1'b1;
                        end
                    end else if (load_tx) begin
                        tx_q      <= rd_byte;
                        oe_q      <= ~rd_byte[7];
                        bit_cnt_q <= 4'h0;
                        mack_q    <= 1'b0;
                        state_q   <= st_tx;
                    end
                end
                default: begin
                    state_q <= st_idle;
                    oe_q    <= 1'b0;
                end
            endcase
        end
    end

    // Register pointer, write pairing and read pairing
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reg_addr_q  <= 8'h00;
            pend_addr_q <= 8'h00;
            hi_q        <= 8'h00;
            lo_q        <= 8'h00;
            wphase_q    <= 1'b0;
            rphase_q    <= 1'b0;
        end else if (start_det) begin
            wphase_q <= 1'b0;
            rphase_q <= 1'b0;
        end else if (rx_done && byte_idx_q == IDX_REGADDR) begin
            // Second byte of a write is the register address
            reg_addr_q <= shreg_q;
        end else if (take_data) begin
            if (reg_addr_q == LOW_BYTE_PORT && !wphase_q) begin
                // Lower byte completes the pending register
                wphase_q <= 1'b0;
            end else if (!wphase_q) begin
                hi_q        <= shreg_q;
                pend_addr_q <= reg_addr_q;
                wphase_q    <= 1'b1;
            end else begin
                wphase_q   <= 1'b0;
                reg_addr_q <= reg_addr_q + 8'h01;
            end
        end else if (load_tx) begin
            if (reg_addr_q == LOW_BYTE_PORT && !rphase_q) begin
                rphase_q <= 1'b0;
            end else if (!rphase_q) begin
                // Lower byte latched with the upper so the word is coherent
                lo_q     <= cur_reg[7:0];
                rphase_q <= 1'b1;
            end else begin
                // Advance as the lower byte of the word is loaded for sending
                rphase_q   <= 1'b0;
                reg_addr_q <= reg_addr_q + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reg_wr_strobe_q <= 1'b0;
            reg_wr_addr_q   <= 8'h00;
            reg_wr_data_q   <= 16'h0000;
        end else begin
            reg_wr_strobe_q <= take_data && (wphase_q || reg_addr_q == LOW_BYTE_PORT);
            if (take_data) begin
                reg_wr_addr_q <= wphase_q ? reg_addr_q : pend_addr_q;
                reg_wr_data_q <= {hi_q, shreg_q};
            end
        end
    end

    // Storage has no reset; values are defined by software writes
    always_ff @(posedge mclk) begin
        if (reg_wr_strobe_q && reg_wr_addr_q < REG_LIMIT) begin
            regs[reg_wr_addr_q[IDX_W-1:0]] <= reg_wr_data_q;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_value_q <= REG_RESET;
            busy_q      <= 1'b0;
            drive_q     <= 1'b0;
        end else begin
            cfg_value_q <= (cfg_index < REG_LIMIT) ? regs[cfg_index[IDX_W-1:0]] : REG_RESET;
            // Idle when the engine waits for a start
            busy_q      <= state_q != st_idle;
            drive_q     <= 1'b0;
        end
    end

    assign serial_data_line_drive = drive_q;
    assign serial_data_line_en    = oe_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence byte_in_s;
        state_q == st_rx && scl_fall && bit_cnt_q == BITS_PER_BYTE;
    endsequence

    start_restart_a: assert property (start_det |=> state_q == st_rx && bit_cnt_q == 4'h0)
        else $error("start did not restart framing");
    stop_release_a: assert property (stop_det |=> state_q == st_idle && !oe_q)
        else $error("stop did not release the bus");
    never_high_a: assert property (!drive_q)
        else $error("data line driven high");
    no_cond_a: assert property (scl_s && scl_p && !start_det && !stop_det |=> $stable(oe_q))
        else $error("data enable moved while clock high");
    addr_ack_a: assert property (byte_in_s ##0 (byte_idx_q == IDX_SLAVE && addr_hit)
        |=> oe_q && state_q == st_ack)
        else $error("own address not acknowledged");
    addr_miss_a: assert property (byte_in_s ##0 (byte_idx_q == IDX_SLAVE && !addr_hit)
        |=> !oe_q && state_q == st_idle)
        else $error("foreign address acknowledged");
    nack_end_a: assert property (state_q == st_rack && scl_rise && sda_s && !start_det
        && !stop_det |=> state_q == st_idle)
        else $error("read continued after no-acknowledge");
    whole_word_a: assert property (reg_wr_strobe_q |-> $past(take_data)
        && ($past(wphase_q) || $past(reg_addr_q) == LOW_BYTE_PORT))
        else $error("partial word committed");
    wr_incr_a: assert property (take_data && wphase_q && !start_det && !stop_det
        |=> reg_addr_q == $past(reg_addr_q) + 8'h01)
        else $error("write pointer not advanced");
    rd_incr_a: assert property (load_tx && rphase_q && !start_det && !stop_det
        |=> reg_addr_q == $past(reg_addr_q) + 8'h01 ##1 1'b1)
        else $error("read pointer not advanced");
endmodule : two_wire_register_slave

//--- host_master.sv
/*
 Behavioural bus master for the two-wire register slave.
 Assumes the bench resolves the data wire from both pull-down enables and a pull-up.
*/
`timescale 1ns/100ps

module host_master (
    input  wire logic sda,
    output logic      scl,
    output logic      m_low
);
    // Extra low time per bit, so the slave also sees a slow master
    int gap = 0;

    initial begin
        scl = 1'b1;
        m_low = 1'b0;
    end

    // Start: data falls while clock high
    task automatic start_cond();
        m_low = 1'b0;
        #40 scl = 1'b1;
        #80 m_low = 1'b1;
        #80 scl = 1'b0;
    endtask : start_cond

    // Stop: data rises while clock high
    task automatic stop_cond();
        #40 m_low = 1'b1;
        #40 scl = 1'b1;
        #80 m_low = 1'b0;
        #80;
    endtask : stop_cond

    // Bits change only with clock low, MSB first, then ack
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #(40 + gap) m_low = ~b[i];
            #40 scl = 1'b1;
            #80 scl = 1'b0;
        end
        #40 m_low = 1'b0;
        #40 scl = 1'b1;
        #40 ack = ~sda;
        #40 scl = 1'b0;
    endtask : put_byte

    // Ack every byte, float high after the last one
    task automatic get_byte(output logic [7:0] b, input logic last);
        for (int i = 7; i >= 0; i--) begin
            #(80 + gap) scl = 1'b1;
            #40 b[i] = sda;
            #40 scl = 1'b0;
        end
        #40 m_low = ~last;
        #40 scl = 1'b1;
        #80 scl = 1'b0;
        // Released late so the slave never sees a data edge with clock high
        #20 m_low = 1'b0;
    endtask : get_byte
endmodule : host_master

//--- test_two_wire_register_slave.sv
/*
 Self-checking bench for the two-wire register slave.
 Assumes host_master drives the serial lines and a pull-up on the data wire.
*/
`timescale 1ns/100ps

module test_two_wire_register_slave;
    import twr_pkg::*;
    logic        mclk, reset_n, addr_select, scl, m_low;
    logic        sdl_drive, sdl_en, wr_stb, busy;
    logic [7:0]  cfg_index, wr_addr;
    logic [15:0] wr_data, cfg_value;
    logic [7:0]  saddr_q[$];
    logic [15:0] serial_data_line_q[$];
    wire logic   sda;
    int          error_cnt, check_count;

    // Wired-AND: nobody pulling low leaves the pull-up level
    assign sda = ~(m_low | sdl_en);

    host_master host_u (.sda(sda), .scl(scl), .m_low(m_low));

    two_wire_register_slave #(.REG_COUNT(127)) dut_u (
        .mclk(mclk), .reset_n(reset_n), .serial_clock_line(scl),
        .serial_data_line_pin(sda), .addr_select(addr_select), .cfg_index(cfg_index),
        .serial_data_line_drive(sdl_drive), .serial_data_line_en(sdl_en),
        .reg_wr_strobe_q(wr_stb), .reg_wr_addr_q(wr_addr), .reg_wr_data_q(wr_data),
        .cfg_value_q(cfg_value), .busy_q(busy)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Sampled mid-cycle so the strobe is settled, never racing its launch edge
    always @(negedge mclk) begin
        if (wr_stb === 1'b1) begin
            saddr_q.push_back(wr_addr);
            serial_data_line_q.push_back(wr_data);
        end
        // Only a low level may ever be driven
        if (sdl_en === 1'b1 && sdl_drive !== 1'b0) begin
            error_cnt++;
            $display("wrong value at %0t: data line driven high", $time);
        end
    end

    task automatic close_out();
        if (error_cnt == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h", $time, m, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] ra, input logic [7:0] d[$]);
        logic a;
        host_u.start_cond();
        host_u.put_byte(8'hb8, a);
        chk(16'(a), 16'h1, "write address ack");
        host_u.put_byte(ra, a);
        chk(16'(a), 16'h1, "register address ack");
        foreach (d[i]) begin
            host_u.put_byte(d[i], a);
            chk(16'(a), 16'h1, "data ack");
        end
        host_u.stop_cond();
    endtask : wr

    task automatic rd(input logic [7:0] ra, input logic [7:0] exp[$]);
        logic       a;
        logic [7:0] b;
        host_u.start_cond();
        host_u.put_byte(8'hb8, a);
        host_u.put_byte(ra, a);
        host_u.start_cond();
        host_u.put_byte(8'hb9, a);
        chk(16'(a), 16'h1, "read address ack");
        foreach (exp[i]) begin
            host_u.get_byte(b, i == exp.size() - 1);
            chk(16'(b), 16'(exp[i]), "read byte");
        end
        host_u.stop_cond();
        chk(16'(sdl_en), 16'h0, "line released after nack");
        chk(16'(busy), 16'h0, "bus idle after stop");
    endtask : rd

    task automatic s_write();
        saddr_q.delete();
        serial_data_line_q.delete();
        wr(8'h09, '{8'h02, 8'h84, 8'h12, 8'h34});
        chk(16'(saddr_q.size()), 16'h2, "commit count");
        chk({saddr_q[0], saddr_q[1]}, 16'h090a, "commit addresses");
        chk(serial_data_line_q[0], 16'h0284, "first word");
        chk(serial_data_line_q[1], 16'h1234, "second word");
        cfg_index = 8'h0a;
        repeat (2) @(posedge mclk);
        #1;
        chk(cfg_value, 16'h1234, "stored word");
    endtask : s_write

    task automatic s_partial();
        saddr_q.delete();
        wr(8'h0a, '{8'h77});
        chk(16'(saddr_q.size()), 16'h0, "half word commits nothing");
        chk(cfg_value, 16'h1234, "register kept");
    endtask : s_partial

    task automatic s_select();
        logic       a;
        // Entries are {ack expected, select level, address byte}
        logic [9:0] tbl [4] = '{10'h3b8, 10'h190, 10'h290, 10'h0b8};
        for (int i = 0; i < 4; i++) begin
            addr_select = tbl[i][8];
            repeat (4) @(posedge mclk);
            #1;
            host_u.start_cond();
            host_u.put_byte(tbl[i][7:0], a);
            host_u.stop_cond();
            chk(16'(a), 16'(tbl[i][9]), "slave address match");
            chk(16'(busy), 16'h0, "idle after stop");
        end
        addr_select = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
    endtask : s_select

    task automatic s_bytewise();
        saddr_q.delete();
        serial_data_line_q.delete();
        host_u.gap = 400;
        wr(8'h0c, '{8'hab});
        chk(16'(saddr_q.size()), 16'h0, "upper byte held");
        wr(LOW_BYTE_PORT, '{8'hcd});
        chk({saddr_q[0], 8'h00}, 16'h0c00, "byte-wise target");
        chk(serial_data_line_q[0], 16'habcd, "byte-wise word");
        rd(8'h0c, '{8'hab});
        rd(LOW_BYTE_PORT, '{8'hcd});
        host_u.gap = 0;
    endtask : s_bytewise

    initial begin
        reset_n = 1'b0;
        addr_select = 1'b1;
        cfg_index = 8'h00;
        error_cnt = 0;
        check_count = 0;
        repeat (2) @(posedge mclk);
        #1;
        chk(16'({sdl_en, wr_stb, busy}), 16'h0, "outputs in reset");
        reset_n = 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        s_write();
        s_partial();
        rd(8'h09, '{8'h02, 8'h84, 8'h12, 8'h34});
        s_select();
        s_bytewise();
        close_out();
    end

    // Whole run needs roughly 100 us; two and a half times that means a hang
    initial begin
        #250000;
        error_cnt++;
        close_out();
    end
endmodule : test_two_wire_register_slave
